// >>> rtl/adcsb_pkg.sv
// adcsb_pkg: constants and types shared by the scan buffer controller.
// assumes a 16-bit host word bus with even byte offsets.
package adcsb_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_CSR = 12'h002;
  localparam logic [11:0] OFS_CCR = 12'h004;
  localparam logic [11:0] OFS_SW_START = 12'h00e;
  localparam logic [11:0] OFS_TIMER_LOW = 12'h020;
  localparam logic [11:0] OFS_GAIN_LO = 12'h040;
  localparam logic [11:0] OFS_GAIN_HI = 12'h07e;
  localparam logic [11:0] OFS_BUF_BASE = 12'h080;

  // ==========================================================================
  // memory geometry
  localparam int MEM_WORDS = 2048;
  localparam logic [10:0] BUF_BASE_WORD = 11'h040;
  localparam logic [10:0] BUF_MIN_WORDS = 11'h010;
  localparam logic [2:0] BUF_CODE_MAX = 3'h6;

  // ==========================================================================
  // control/status word fields
  localparam int CSR_SW = 15;
  localparam int CSR_CODING = 14;
  localparam int CSR_TIMER = 13;
  localparam int CSR_EXT = 12;
  localparam int CSR_CASCADE = 11;
  localparam int CSR_LED = 9;
  localparam int CSR_MIDSCAN = 8;
  localparam int CSR_READY = 6;
  localparam logic [15:0] CSR_RESET = 16'h0000;

  // ==========================================================================
  // channel configuration word fields
  localparam int CCR_BUF_HI = 15;
  localparam int CCR_BUF_LO = 13;
  localparam int CCR_AUTO_GAIN = 9;
  localparam int CCR_FIX_X10 = 8;
  localparam int CCR_MODE_HI = 7;
  localparam int CCR_MODE_LO = 6;
  localparam int CCR_BLK_HI = 5;
  localparam int CCR_BLK_LO = 3;
  localparam int CCR_GRP_HI = 2;
  localparam logic [15:0] CCR_RESET = 16'h5800;
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SAMPLE_NS = 10000;
  localparam int SAMPLE_CYC = SAMPLE_NS / CLK_PERIOD_NS;
  localparam int TIMER_STEP_NS = 160;
  localparam int TIMER_STEP_CYC = (TIMER_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_CONV = 2'h3,
    ST_PUSH = 2'h2
  } adcsb_state_t;

endpackage

// >>> rtl/adcsb_fifo.sv
// adcsb_fifo: small valid/ready buffer between conversion and memory.
// assumes one clock; depth a power of two.
`timescale 1ns/1ps
module adcsb_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } adcsb_fifo_t;

  adcsb_fifo_t s;
  adcsb_fifo_t next_s;
  logic [WIDTH-1:0] store [DEPTH];
  logic push;
  logic pop;

  assign in_ready_out = (s.count != (PW+1)'(DEPTH));
  assign out_valid_out = (s.count != '0);
  assign out_data_out = store[s.rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_comb
  begin
    next_s = s;
    if (push)
    begin
      next_s.wr_ptr = PW'(s.wr_ptr + 1'b1);
    end
    if (pop)
    begin
      next_s.rd_ptr = PW'(s.rd_ptr + 1'b1);
    end
    next_s.count = (PW+1)'(s.count + (PW+1)'(push) - (PW+1)'(pop));
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // data slots carry no reset; only the count defines validity
  always_ff @(posedge clk_sys_in)
  begin
    if (push)
    begin
      store[s.wr_ptr] <= in_data_in;
    end
  end

endmodule

// >>> rtl/adcsb_ctrl.sv
// adcsb_ctrl: scan sequencer, coding, gain select and dual-port buffer.
// assumes a converter that answers a start pulse with a done level and
// held data, and a host word bus with one-cycle read/write strobes.
`timescale 1ns/1ps
module adcsb_ctrl
  import adcsb_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [11:0] host_addr_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  input wire logic [15:0] host_wdata_in,
  output logic [15:0] host_rdata_out,
  output logic host_rvalid_out,
  input wire logic external_start_n_in,
  output logic adc_start_out,
  output logic [5:0] adc_channel_out,
  output logic adc_gain_x10_out,
  input wire logic adc_done_in,
  input wire logic [15:0] adc_data_in,
  output logic scan_busy_out,
  output logic data_ready_out,
  output logic indicator_out
);

  // last flag, half flag, 11-bit word address, 16-bit sample
  localparam int PAY_W = 29;

  typedef struct packed {
    adcsb_state_t st;
    logic [15:0] control_status_word;
    logic [15:0] channel_config_word;
    logic [63:0] gain;
    logic [15:0] timer_load;
    logic [15:0] timer_cnt;
    logic [2:0] tick_cnt;
    logic [7:0] rate_cnt;
    logic [9:0] pos;
    logic [15:0] sample;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    logic [15:0] data_s1;
    logic [15:0] data_s2;
    logic ready;
    logic busy;
    logic adc_start;
    logic [5:0] adc_ch;
    logic adc_gain;
    logic rvalid;
  } adcsb_ctrl_t;

  adcsb_ctrl_t s;
  adcsb_ctrl_t next_s;
  logic [15:0] mem [MEM_WORDS];
  logic [15:0] rdata;
  logic [15:0] reg_rd;
  logic [1:0] mode;
  logic [2:0] buf_code;
  logic [10:0] buf_words;
  logic [9:0] last_pos;
  logic [6:0] blk_size;
  logic [5:0] blk_mask;
  logic [5:0] first_ch;
  logic [5:0] cur_ch;
  logic host_mem;
  logic host_buf;
  logic wr_ccr;
  logic sw_trig;
  logic ext_fall;
  logic timer_exp;
  logic done_rise;
  logic trig;
  logic fin_valid;
  logic fin_ready;
  logic [PAY_W-1:0] fin_data;
  logic fout_valid;
  logic fout_ready;
  logic [PAY_W-1:0] fout_data;
  logic mem_set_ready;

  // ==========================================================================
  // geometry decode
  assign mode = s.channel_config_word[CCR_MODE_HI:CCR_MODE_LO];
  assign buf_code = (s.channel_config_word[CCR_BUF_HI:CCR_BUF_LO] > BUF_CODE_MAX) ? BUF_CODE_MAX
                    : s.channel_config_word[CCR_BUF_HI:CCR_BUF_LO];
  assign buf_words = BUF_MIN_WORDS << buf_code;
  assign last_pos = 10'(buf_words - 11'h001);

  always_comb
  begin
    case (s.channel_config_word[CCR_BLK_HI:CCR_BLK_LO])
      3'h0: blk_size = 7'h40;
      3'h1: blk_size = 7'h20;
      3'h2: blk_size = 7'h10;
      3'h3: blk_size = 7'h08;
      default: blk_size = 7'h01;
    endcase
  end

  assign blk_mask = 6'(blk_size - 7'h01);
  assign first_ch = 6'({4'h0, s.channel_config_word[CCR_GRP_HI:0]} * blk_size);
  assign cur_ch = 6'(first_ch + (s.pos[5:0] & blk_mask));

  // ==========================================================================
  // host decode and triggers
  assign host_mem = (host_addr_in >= OFS_BUF_BASE);
  assign host_buf = host_mem && ((host_addr_in[11:1] - BUF_BASE_WORD) < buf_words);
  assign wr_ccr = host_wr_in && (host_addr_in == OFS_CCR);
  assign sw_trig = host_wr_in && (host_addr_in == OFS_SW_START) && s.control_status_word[CSR_SW]
                   && !s.control_status_word[CSR_EXT] && !s.control_status_word[CSR_TIMER];
  // falling edge, read from the settled stages only
  assign ext_fall = s.ext_s3 && !s.ext_s2 && s.control_status_word[CSR_EXT] && !s.control_status_word[CSR_TIMER];
  assign timer_exp = s.control_status_word[CSR_TIMER] && (s.timer_load != '0)
                     && (s.tick_cnt == 3'(TIMER_STEP_CYC - 1)) && (s.timer_cnt <= 16'h0001);
  assign trig = sw_trig || ext_fall || timer_exp;
  assign done_rise = s.done_s2 && !s.done_s3;

  always_comb
  begin
    reg_rd = 16'h0000;
    if (host_addr_in == OFS_CSR)
    begin
      reg_rd = s.control_status_word;
      reg_rd[CSR_READY] = s.ready;
    end
    else if (host_addr_in == OFS_CCR)
    begin
      reg_rd = s.channel_config_word;
    end
    else if (host_addr_in == OFS_TIMER_LOW)
    begin
      reg_rd = s.timer_load;
    end
    else if ((host_addr_in >= OFS_GAIN_LO) && (host_addr_in <= OFS_GAIN_HI))
    begin
      reg_rd = {15'h0000, s.gain[host_addr_in[6:1]]};
    end
  end

  // ==========================================================================
  // next state
  always_comb
  begin
    next_s = s;
    next_s.adc_start = 1'b0;
    next_s.rvalid = host_rd_in;
    next_s.ext_s1 = external_start_n_in;
    next_s.ext_s2 = s.ext_s1;
    next_s.ext_s3 = s.ext_s2;
    next_s.done_s1 = adc_done_in;
    next_s.done_s2 = s.done_s1;
    next_s.done_s3 = s.done_s2;
    next_s.data_s1 = adc_data_in;
    next_s.data_s2 = s.data_s1;
    if (host_wr_in)
    begin
      // control word holds trigger, coding and indicator choice
      if (host_addr_in == OFS_CSR)
      begin
        next_s.control_status_word = host_wdata_in;
        next_s.control_status_word[CSR_READY] = 1'b0;
      end
      if (wr_ccr)
      begin
        next_s.channel_config_word = host_wdata_in;
      end
      if (host_addr_in == OFS_TIMER_LOW)
      begin
        next_s.timer_load = host_wdata_in;
        next_s.timer_cnt = host_wdata_in;
        next_s.tick_cnt = '0;
      end
      if ((host_addr_in >= OFS_GAIN_LO) && (host_addr_in <= OFS_GAIN_HI))
      begin
        next_s.gain[host_addr_in[6:1]] = host_wdata_in[0];
      end
    end
    if (!s.control_status_word[CSR_TIMER])
    begin
      next_s.tick_cnt = '0;
      next_s.timer_cnt = s.timer_load;
    end
    else if (s.tick_cnt == 3'(TIMER_STEP_CYC - 1))
    begin
      next_s.tick_cnt = '0;
      next_s.timer_cnt = (s.timer_cnt <= 16'h0001) ? s.timer_load : 16'(s.timer_cnt - 16'h0001);
    end
    else
    begin
      next_s.tick_cnt = 3'(s.tick_cnt + 3'h1);
    end
    if (s.rate_cnt != '0)
    begin
      next_s.rate_cnt = 8'(s.rate_cnt - 8'h01);
    end
    case (s.st)
      ST_IDLE:
      begin
        if (mode == MODE_AUTO)
        begin
          next_s.st = ST_WAIT;
          next_s.pos = '0;
        end
        else if ((mode == MODE_SINGLE) && trig)
        begin
          next_s.st = ST_WAIT;
          next_s.pos = '0;
        end
      end
      ST_WAIT:
      begin
        if (s.rate_cnt == '0)
        begin
          next_s.adc_start = 1'b1;
          next_s.adc_ch = cur_ch;
          next_s.adc_gain = s.channel_config_word[CCR_AUTO_GAIN] ? s.gain[cur_ch] : s.channel_config_word[CCR_FIX_X10];
          next_s.rate_cnt = 8'(SAMPLE_CYC - 1);
          next_s.st = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (done_rise)
        begin
          // coding select: msb flip turns offset binary into two's complement
          next_s.sample = {s.data_s2[15] ^ s.control_status_word[CSR_CODING], s.data_s2[14:0]};
          next_s.st = ST_PUSH;
        end
      end
      ST_PUSH:
      begin
        // a full buffer holds the scan here rather than dropping a word
        if (fin_ready)
        begin
          if (s.pos == last_pos)
          begin
            next_s.pos = '0;
            next_s.st = (mode == MODE_AUTO) ? ST_WAIT : ST_IDLE;
          end
          else
          begin
            next_s.pos = 10'(s.pos + 10'h001);
            next_s.st = ST_WAIT;
          end
        end
      end
      default:
      begin
        next_s.st = ST_IDLE;
      end
    endcase
    // a new configuration abandons the scan in progress
    if (wr_ccr)
    begin
      next_s.st = ST_IDLE;
      next_s.pos = '0;
    end
    // set wins over the clear by a buffer read
    next_s.ready = (s.ready && !(host_rd_in && host_buf)) || mem_set_ready;
    next_s.busy = (next_s.st != ST_IDLE);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s <= '0;
      s.control_status_word <= CSR_RESET;
      s.channel_config_word <= CCR_RESET;
      s.ext_s1 <= 1'b1;
      s.ext_s2 <= 1'b1;
      s.ext_s3 <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // buffer between converter and memory
  // offset from the buffer base grows with position
  assign fin_valid = (s.st == ST_PUSH);
  assign fin_data = {(s.pos == last_pos), (s.pos == 10'(last_pos >> 1)), BUF_BASE_WORD + 11'(s.pos), s.sample};
  // host writes own the memory port; the scan waits
  assign fout_ready = !(host_wr_in && host_mem);
  assign mem_set_ready = fout_valid && fout_ready
                         && (s.control_status_word[CSR_MIDSCAN] ? fout_data[27] : fout_data[28]);

  adcsb_fifo #(
    .WIDTH(PAY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(fin_valid),
    .in_ready_out(fin_ready),
    .in_data_in(fin_data),
    .out_valid_out(fout_valid),
    .out_ready_in(fout_ready),
    .out_data_out(fout_data)
  );

  // 2048-word memory, scratch above and beside the buffer
  always_ff @(posedge clk_sys_in)
  begin
    if (host_wr_in && host_mem)
    begin
      mem[host_addr_in[11:1]] <= host_wdata_in;
    end
    else if (fout_valid)
    begin
      mem[fout_data[26:16]] <= fout_data[15:0];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata <= '0;
    end
    else if (host_rd_in)
    begin
      rdata <= host_mem ? mem[host_addr_in[11:1]] : reg_rd;
    end
  end

  assign host_rdata_out = rdata;
  assign host_rvalid_out = s.rvalid;
  assign adc_start_out = s.adc_start;
  assign adc_channel_out = s.adc_ch;
  assign adc_gain_x10_out = s.adc_gain;
  assign scan_busy_out = s.busy;
  assign data_ready_out = s.ready;
  assign indicator_out = s.control_status_word[CSR_LED];

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence seq_ext_edge;
    s.ext_s3 && !s.ext_s2;
  endsequence

  sequence seq_single_idle;
    (s.st == ST_IDLE) && (mode == MODE_SINGLE) && !wr_ccr;
  endsequence

  a_coding_msb_flip: assert property (done_rise && (s.st == ST_CONV) && !wr_ccr |=>
    s.sample == {$past(s.data_s2[15]) ^ $past(s.control_status_word[CSR_CODING]), $past(s.data_s2[14:0])})
    else $error("stored sample coding wrong");
  a_ready_at_end: assert property (fout_valid && fout_ready && fout_data[28] && !s.control_status_word[CSR_MIDSCAN]
    |=> data_ready_out)
    else $error("data ready not set after last word");
  a_busy_no_restart: assert property ((s.st == ST_WAIT) && $past(s.st == ST_WAIT) && !$past(wr_ccr)
    |-> s.pos == $past(s.pos))
    else $error("scan position moved while waiting");
  a_single_scan_halts: assert property ((mode == MODE_SINGLE) && (s.st == ST_PUSH) && fin_ready
    && (s.pos == last_pos) && !wr_ccr |=> s.st == ST_IDLE)
    else $error("single scan did not halt");
  a_auto_runs_free: assert property ((mode == MODE_AUTO) && (s.st == ST_IDLE) && !wr_ccr
    |=> s.st == ST_WAIT ##1 (s.st == ST_CONV) || wr_ccr || $past(wr_ccr) || (s.rate_cnt != 0))
    else $error("auto scan did not start");
  a_sw_start_scan: assert property (seq_single_idle and sw_trig |=> (s.st == ST_WAIT) && (s.pos == 0))
    else $error("software write did not start scan");
  a_ext_start_scan: assert property (seq_ext_edge ##0 seq_single_idle ##0 ext_fall
    |=> s.st == ST_WAIT)
    else $error("external edge did not start scan");
  a_rate_spacing: assert property (adc_start_out |-> ##1 (!adc_start_out)[*8])
    else $error("conversions too close together");
  a_buf_in_range: assert property (fout_valid |-> (fout_data[26:16] >= BUF_BASE_WORD)
    && ((fout_data[26:16] - BUF_BASE_WORD) < 11'h400))
    else $error("scan wrote outside the buffer");
  a_timer_reload: assert property (timer_exp && !(host_wr_in && host_addr_in == OFS_TIMER_LOW)
    |=> s.timer_cnt == s.timer_load)
    else $error("timer did not reload on expiry");

endmodule

// >>> sim/adcsb_conv_model.sv
// adcsb_conv_model: behavioural converter on the far side of the converter link.
// assumes one start pulse per conversion, spaced well apart by the controller.
`timescale 1ns/1ps
module adcsb_conv_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [5:0] channel_in,
  input wire logic gain_x10_in,
  input wire logic [15:0] salt_in,
  input wire logic slow_in,
  output logic done_out,
  output logic [15:0] data_out
);
  logic [7:0] age;
  logic [7:0] lat;
  logic [15:0] held;
  // ==========================================================================
  // conversion timing
  // result frozen at start, so later channel changes cannot leak in
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      age <= 8'h00;
      held <= 16'h0000;
    end
    else if (start_in)
    begin
      age <= 8'h01;
      held <= salt_in ^ {channel_in, 9'h000, gain_x10_in};
    end
    else if (age != 8'h00 && age != 8'hff)
      age <= age + 8'h01;
  end
  assign lat = slow_in ? 8'h28 : 8'h03;
  // done stands six cycles; outside it the data lines show garbage
  assign done_out = (age >= lat) && (age < lat + 8'h06);
  assign data_out = done_out ? held : ~held;
endmodule

// >>> sim/testbench.sv
// testbench: host-side stimulus and checks for the scan buffer controller.
// assumes the converter model stands on the converter link.
`timescale 1ns/1ps
module testbench;
  import adcsb_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [11:0] addr = 12'h000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic ext_n = 1'b1;
  logic [15:0] salt = 16'h0000;
  logic slow = 1'b0;
  logic [15:0] rdata;
  logic [15:0] adata;
  logic [15:0] d;
  logic [5:0] ch;
  logic rvalid, start, gain, done, busy, ready, led;
  logic [15:0] exp_q[$];
  int bad_count = 0;
  int n_tests = 0;

  always #25 clk_sys_in = ~clk_sys_in;

  adcsb_ctrl i_adcsb_ctrl (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .host_addr_in(addr), .host_wr_in(wr),
    .host_rd_in(rd), .host_wdata_in(wdata), .host_rdata_out(rdata), .host_rvalid_out(rvalid),
    .external_start_n_in(ext_n), .adc_start_out(start), .adc_channel_out(ch), .adc_gain_x10_out(gain),
    .adc_done_in(done), .adc_data_in(adata), .scan_busy_out(busy), .data_ready_out(ready),
    .indicator_out(led));
  adcsb_conv_model i_adcsb_conv_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .start_in(start),
    .channel_in(ch), .gain_x10_in(gain), .salt_in(salt), .slow_in(slow), .done_out(done), .data_out(adata));

  // ==========================================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_tests++;
    if (seen !== want)
    begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic chk1(input logic seen, input logic want);
    check({15'h0000, seen}, {15'h0000, want});
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [15:0] v);
    @(negedge clk_sys_in);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk_sys_in);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, input logic [15:0] want);
    @(negedge clk_sys_in);
    addr = a;
    rd = 1'b1;
    exp_q.push_back(want);
    @(negedge clk_sys_in);
    rd = 1'b0;
  endtask

  // bounded wait on busy or, with sel_ready, on the data-ready flag
  task automatic wait_sig(input logic sel_ready, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      if ((sel_ready ? ready : busy) === lvl)
        break;
      @(negedge clk_sys_in);
    end
    chk1(sel_ready ? ready : busy, lvl);
  endtask

  function automatic logic [15:0] raw(input logic [5:0] c, input logic g);
    return salt ^ {c, 9'h000, g};
  endfunction

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================================
  // answer monitor: oldest note against each read answer
  // sampled mid-cycle, where the registered answer has settled
  always @(negedge clk_sys_in)
  begin
    if (rvalid === 1'b1)
    begin
      if (exp_q.size() != 0)
        check(rdata, exp_q.pop_front());
      else
        check(rdata ^ 16'hffff, rdata);
    end
  end

  initial
  begin
    #3000000;
    bad_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    complete_run();
  end

  // ==========================================================================
  // tests
  initial
  begin
    salt = $urandom(32'h610e);
    slow = $urandom;
    repeat (2) @(negedge clk_sys_in);
    rst_in = 1'b0;
    rd_reg(OFS_CSR, CSR_RESET);
    rd_reg(OFS_CCR, CCR_RESET);
    chk1(led, 1'b0);
    rd_reg(12'h010, 16'h0000);
    d = $urandom;
    wr_reg(12'h880, d);
    rd_reg(12'h880, d);
    wr_reg(12'hffe, ~d);
    rd_reg(12'hffe, ~d);
    $display("test reset_scratch done");
    wait_sig(1'b1, 1'b1, 14000);
    rd_reg(OFS_CSR, 16'h0040);
    for (int p = 0; p < 64; p += 21)
      rd_reg(OFS_BUF_BASE + 12'(2 * p), raw(6'(p), 1'b0));
    $display("test auto_scan done");
    // two's complement, 16-word buffer, 16-channel block, group 1
    wr_reg(OFS_CSR, 16'hc000);
    wr_reg(OFS_CCR, 16'h0051);
    repeat (60) @(negedge clk_sys_in);
    wait_sig(1'b0, 1'b0, 300);
    salt = $urandom;
    slow = $urandom;
    d = $urandom;
    wr_reg(12'h0a0, d);
    wr_reg(OFS_SW_START, 16'($urandom));
    wait_sig(1'b0, 1'b1, 10);
    wr_reg(OFS_SW_START, 16'h0000);
    wait_sig(1'b0, 1'b0, 4000);
    // last word still in the buffer stage when busy drops
    repeat (2) @(negedge clk_sys_in);
    chk1(ready, 1'b1);
    rd_reg(OFS_CSR, 16'hc040);
    for (int p = 0; p < 16; p += 5)
      rd_reg(OFS_BUF_BASE + 12'(2 * p), raw(6'(16 + p), 1'b0) ^ 16'h8000);
    rd_reg(12'h0a0, d);
    repeat (300) @(negedge clk_sys_in);
    chk1(busy, 1'b0);
    chk1(ready, 1'b0);
    $display("test single_software done");
    wr_reg(OFS_CSR, 16'h9200);
    wr_reg(OFS_CCR, 16'h0151);
    rd_reg(OFS_CSR, 16'h9200);
    chk1(led, 1'b1);
    salt = $urandom;
    slow = ~slow;
    @(negedge clk_sys_in);
    ext_n = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    ext_n = 1'b1;
    wait_sig(1'b0, 1'b1, 10);
    wait_sig(1'b0, 1'b0, 4000);
    for (int p = 0; p < 16; p += 5)
      rd_reg(OFS_BUF_BASE + 12'(2 * p), raw(6'(16 + p), 1'b1));
    $display("test single_external done");
    wr_reg(OFS_TIMER_LOW, 16'h03e8);
    rd_reg(OFS_TIMER_LOW, 16'h03e8);
    wr_reg(OFS_CSR, 16'ha000);
    wait_sig(1'b0, 1'b1, 4100);
    wait_sig(1'b0, 1'b0, 4000);
    repeat (500) @(negedge clk_sys_in);
    chk1(busy, 1'b0);
    wait_sig(1'b0, 1'b1, 500);
    $display("test interval_timer done");
    complete_run();
  end
endmodule
